/* File: core/itpm_params.svh */
/*
 * Constants of the initiator task pointer manager: widths, slot count and
 * reconnect timing.
 * Assumes it is included by bare name before the package and the modules.
 */
`ifndef ITPM_PARAMS_SVH
`define ITPM_PARAMS_SVH

// ****************************************************************
// Widths and counts
// ****************************************************************
`define ITPM_PTR_W       32
`define ITPM_ID_W        4
`define ITPM_NUM_SETS    15
`define ITPM_SLOT_W      (4 * `ITPM_PTR_W)

// ****************************************************************
// Timing
// ****************************************************************
`define ITPM_RECON_CYCLES 2

`endif

/* File: core/itpm_pkg.sv */
/*
 * Types of the initiator task pointer manager: pointer sets, slot entries,
 * request carrier and state codes.
 * Assumes itpm_params.svh is on the include path.
 */
`include "itpm_params.svh"

package itpm_pkg;

    // ****************************************************************
    // Pointer types
    // ****************************************************************
    typedef logic [`ITPM_PTR_W-1:0] itpm_ptr_t;
    typedef logic [`ITPM_ID_W-1:0]  itpm_id_t;

    // Command, status and data pointers of one task
    typedef struct packed {
        itpm_ptr_t cmd;
        itpm_ptr_t sts;
        itpm_ptr_t dat;
    } itpm_set_s;

    // Saved slot: task start values plus the saved data pointer
    typedef struct packed {
        itpm_set_s start;
        itpm_ptr_t dat_sv;
    } itpm_slot_s;

    // ****************************************************************
    // Requests
    // ****************************************************************
    typedef enum logic [2:0] {
        OP_START   = 3'h0,
        OP_NEXT    = 3'h1,
        OP_RESTORE = 3'h2,
        OP_SAVE_DP = 3'h3,
        OP_MODIFY  = 3'h4,
        OP_DISC    = 3'h5,
        OP_RECON   = 3'h6,
        OP_NONE    = 3'h7
    } itpm_op_e;

    typedef struct packed {
        itpm_op_e  op;
        itpm_id_t  id;
        itpm_set_s ptrs;
        itpm_ptr_t delta;
    } itpm_req_s;

    typedef enum logic [0:0] {
        ST_IDLE = 1'b0,
        ST_LOAD = 1'b1
    } itpm_st_e;

endpackage : itpm_pkg

/* File: core/itpm_ptr_mgr.sv */
/*
 * Initiator task pointer manager: one active pointer set, per-target saved
 * sets, save on disconnect, restore on reconnect, pointer message handling.
 * Assumes requests come from the initiator's bus sequencer, one at a time,
 * synchronous to clock, and only while busy is low.
 */
// How it works
// RQ1: Every pointer set holds command, status and data pointers together.
// RQ2: One active set, up to fifteen saved sets selected by target.
// RQ3: Good status lets the next task's pointers load at once.
// RQ4: Restore reloads active set with the task's starting pointers.
// RQ5: Each active target keeps its saved set, connected or not.
// RQ6: Saved command and status always hold first-byte addresses.
// RQ7: A disconnect writes the current pointers into the target's slot; the code writes start_q and sav_q, not act_q.dat after a restore.
// RQ8: Save data pointers copies the active data pointer into the slot.
// RQ9: Reconnect copies the target's saved set into the active set.
// RQ10: Without save or modify, the restored data pointer is the data start.
// RQ11: Modify data pointers adds a signed offset to the data pointer.
// RQ12: Users must not read the data pointer as a transfer length.
// RQ13: The slot is selected by the target's bus identifier.
`timescale 1ns/1ns

module itpm_ptr_mgr
    import itpm_pkg::*;
#(
    parameter int NUM_SETS = `ITPM_NUM_SETS
) (
    // Clock and reset
    input  wire logic      clock,
    input  wire logic      rst,
    // Request port
    input  wire logic      req_valid,
    input  wire itpm_req_s req,
    // Pointer state
    output itpm_set_s      act_q,
    output itpm_id_t       cur_id_q,
    output logic           connected_q,
    output logic           busy_q,
    output logic           reject_q
);

    // Elaboration check: slot index is the bus id, so at most fifteen slots
    if (NUM_SETS < 1 || NUM_SETS > `ITPM_NUM_SETS) begin : g_bad_sets
        $error("itpm_ptr_mgr: NUM_SETS must be 1 to 15");
    end

    // ****************************************************************
    // State
    // ****************************************************************
    itpm_st_e   st_q,    st_d;
    itpm_set_s  start_q, start_d;
    itpm_ptr_t  sav_q,   sav_d;
    itpm_set_s  act_d;
    itpm_id_t   id_d;
    logic       conn_d;
    itpm_slot_s rd_slot;
    logic       wr_en;
    itpm_id_t   wr_addr;
    itpm_slot_s wr_data;

    // Request qualification
    wire        take    = req_valid && (st_q == ST_IDLE);
    wire        id_ok   = req.id < NUM_SETS;                                // RQ2
    wire        is_new  = take && req.op == OP_START && id_ok && !connected_q;
    wire        is_next = take && req.op == OP_NEXT && connected_q;
    wire        is_rest = take && req.op == OP_RESTORE && connected_q;
    wire        is_save = take && req.op == OP_SAVE_DP && connected_q;
    wire        is_mod  = take && req.op == OP_MODIFY && connected_q;
    wire        is_disc = take && req.op == OP_DISC && connected_q;
    wire        is_rec  = take && req.op == OP_RECON && id_ok && !connected_q;
    wire        good    = is_new || is_next || is_rest || is_save || is_mod || is_disc || is_rec;
    wire        loading = st_q == ST_LOAD;
    wire itpm_ptr_t mod_dat = act_q.dat + req.delta;                        // RQ11

    // Slot write selection: slot follows the target identifier
    assign wr_en   = is_new || is_next || is_save || is_mod || is_disc;     // RQ5
    assign wr_addr = is_new ? req.id : cur_id_q;                            // RQ13
    assign wr_data.start  = (is_new || is_next) ? req.ptrs : start_q;       // RQ6
    assign wr_data.dat_sv = (is_new || is_next) ? req.ptrs.dat :            // RQ10
                            is_save ? act_q.dat :                           // RQ8
                            is_mod  ? mod_dat : sav_q;                      // RQ7

    // ****************************************************************
    // Saved slot storage
    // ****************************************************************
    itpm_slot_mem #(
        .W     (`ITPM_SLOT_W),
        .DEPTH (NUM_SETS),
        .AW    (`ITPM_ID_W)
    ) u_slots (
        .clock     (clock),
        .rst       (rst),
        .wr_en     (wr_en),
        .wr_addr   (wr_addr),
        .wr_data   (wr_data),
        .rd_en     (is_rec),
        .rd_addr   (req.id),                                                // RQ13
        .rd_data_q (rd_slot)
    );

    // ****************************************************************
    // Next-state selection
    // ****************************************************************
    always_comb begin
        st_d    = st_q;
        act_d   = act_q;
        start_d = start_q;
        sav_d   = sav_q;
        id_d    = cur_id_q;
        conn_d  = connected_q;
        case (st_q)
            ST_IDLE: begin
                if (is_new || is_next) begin
                    act_d   = req.ptrs;                                     // RQ3
                    start_d = req.ptrs;                                     // RQ1
                    sav_d   = req.ptrs.dat;
                    conn_d  = 1'b1;
                    if (is_new) begin
                        id_d = req.id;
                    end
                end else if (is_rest) begin
                    act_d = start_q;                                        // RQ4
                end else if (is_save) begin
                    sav_d = act_q.dat;                                      // RQ8
                end else if (is_mod) begin
                    act_d.dat = mod_dat;                                    // RQ11
                    sav_d     = mod_dat;
                end else if (is_disc) begin
                    conn_d = 1'b0;                                          // RQ7
                end else if (is_rec) begin
                    id_d = req.id;
                    st_d = ST_LOAD;
                end
            end
            ST_LOAD: begin
                act_d.cmd = rd_slot.start.cmd;                              // RQ9
                act_d.sts = rd_slot.start.sts;
                act_d.dat = rd_slot.dat_sv;
                start_d   = rd_slot.start;
                sav_d     = rd_slot.dat_sv;
                conn_d    = 1'b1;
                st_d      = ST_IDLE;
            end
            default: begin
                st_d = ST_IDLE;
            end
        endcase
    end

    // ****************************************************************
    // Registers
    // ****************************************************************
    always_ff @(posedge clock) begin
        if (rst) begin
            st_q        <= ST_IDLE;
            act_q       <= '0;
            start_q     <= '0;
            sav_q       <= '0;
            cur_id_q    <= '0;
            connected_q <= 1'b0;
        end else begin
            st_q        <= st_d;
            act_q       <= act_d;
            start_q     <= start_d;
            sav_q       <= sav_d;
            cur_id_q    <= id_d;
            connected_q <= conn_d;
        end
    end

    // Status flags
    always_ff @(posedge clock) begin
        if (rst) begin
            busy_q   <= 1'b0;
            reject_q <= 1'b0;
        end else begin
            busy_q   <= st_d == ST_LOAD;
            reject_q <= req_valid && !good;
        end
    end

    // ****************************************************************
    // Checks
    // ****************************************************************
    default clocking cb @(posedge clock); endclocking
    default disable iff (rst);

    // Helper: data pointer moved since the task started
    logic moved_q;
    always_ff @(posedge clock) begin
        if (rst) begin
            moved_q <= 1'b0;
        end else if (is_new || is_next) begin
            moved_q <= 1'b0;
        end else if (is_save || is_mod || loading) begin
            moved_q <= 1'b1;
        end
    end

    sequence s_recon_take;
        is_rec;
    endsequence

    sequence s_recon_done;
        busy_q && !connected_q ##1 !busy_q && connected_q;
    endsequence

    chk_restore_start: assert property (is_rest |=> act_q == $past(start_q)) // RQ4
        else $error("restore did not load the starting pointers");
    chk_next_task_load: assert property (is_next |=> act_q == $past(req.ptrs) && start_q == act_q) // RQ3
        else $error("next task pointers not loaded");
    chk_modify_adds: assert property (is_mod |=> act_q.dat == $past(act_q.dat) + $past(req.delta)) // RQ11
        else $error("modify did not add the offset");
    chk_save_copy: assert property (is_save |-> wr_en && wr_data.dat_sv == act_q.dat) // RQ8
        else $error("save data pointers not written to slot");
    chk_disc_writes: assert property (is_disc |-> wr_en && wr_addr == cur_id_q ##1 !connected_q) // RQ7
        else $error("disconnect did not save and drop the link");
    chk_disc_dat_start: assert property (is_disc && !moved_q |-> wr_data.dat_sv == start_q.dat) // RQ10
        else $error("unsaved data pointer not at data start");
    chk_recon_seq: assert property (s_recon_take |=> s_recon_done) // RQ9
        else $error("reconnect did not restore within two cycles");
    chk_recon_first: assert property ($fell(busy_q) |-> act_q.cmd == start_q.cmd && act_q.sts == start_q.sts) // RQ6
        else $error("restored command or status not at first byte");
    chk_slot_select: assert property (is_rec |=> cur_id_q == $past(req.id)) // RQ13
        else $error("reconnect slot not chosen by target id");
    chk_sets_limit: assert property (connected_q |-> cur_id_q < NUM_SETS) // RQ2
        else $error("connected target beyond the saved set count");
    chk_busy_refuse: assert property (req_valid && loading |=> reject_q && !busy_q) // RQ9
        else $error("request during reconnect load was not refused");

endmodule : itpm_ptr_mgr

/* File: core/itpm_slot_mem.sv */
/*
 * Saved pointer slot memory: one write port, one read port with registered
 * read data, one entry per target bus identifier.
 * Assumes a single clock and a synchronous active-high reset.
 */
`timescale 1ns/1ns

module itpm_slot_mem #(
    parameter int W     = 128,
    parameter int DEPTH = 15,
    parameter int AW    = 4
) (
    // Clock and reset
    input  wire logic          clock,
    input  wire logic          rst,
    // Write port
    input  wire logic          wr_en,
    input  wire logic [AW-1:0] wr_addr,
    input  wire logic [W-1:0]  wr_data,
    // Read port
    input  wire logic          rd_en,
    input  wire logic [AW-1:0] rd_addr,
    output logic      [W-1:0]  rd_data_q
);

    // Elaboration check: every entry must be reachable by the address
    if (DEPTH < 1 || DEPTH > (1 << AW)) begin : g_bad_depth
        $error("itpm_slot_mem: DEPTH does not fit the address width");
    end

    logic [W-1:0] mem [DEPTH];

    // ****************************************************************
    // Storage and registered read
    // ****************************************************************
    always_ff @(posedge clock) begin
        if (wr_en) begin
            mem[wr_addr] <= wr_data;
        end
    end

    // Read data register, cleared by reset
    always_ff @(posedge clock) begin
        if (rst) begin
            rd_data_q <= '0;
        end else if (rd_en) begin
            rd_data_q <= mem[rd_addr];
        end
    end

endmodule : itpm_slot_mem

/* File: test/itpm_ptr_mgr_test.sv */
/*
 * Self-checking bench of the pointer manager: reset values, table of message
 * rows, then busy refusal and mid-run reset by hand.
 * Assumes the package and itpm_target are compiled first.
 */
`timescale 1ns/1ns

module itpm_ptr_mgr_test
    import itpm_pkg::*;
;
    typedef struct packed {
        itpm_req_s r;
        logic      ca;
        itpm_set_s ea;
        logic      cn;
        logic      er;
    } itpm_row_s;

    logic       clock = 1'b0;
    logic       rst   = 1'b1;
    logic       req_valid;
    itpm_req_s  req;
    itpm_set_s  act_q;
    itpm_id_t   cur_id_q;
    logic       connected_q;
    logic       busy_q;
    logic       reject_q;
    int         mismatches  = 0;
    int         comparisons = 0;
    itpm_row_s  rows[$];

    // ****************************************************************
    // Instances
    // ****************************************************************
    itpm_ptr_mgr #(.NUM_SETS(15)) itpm_ptr_mgr_inst (
        .clock(clock), .rst(rst), .req_valid(req_valid), .req(req), .act_q(act_q),
        .cur_id_q(cur_id_q), .connected_q(connected_q), .busy_q(busy_q), .reject_q(reject_q));

    itpm_target itpm_target_inst (.clock(clock), .req_valid(req_valid), .req(req));

    // Clock of 20 ns
    always #10 clock = ~clock;

    // ****************************************************************
    // Helpers
    // ****************************************************************
    function automatic itpm_req_s mk(input itpm_op_e op, input itpm_id_t id,
                                     input logic [11:0] c, s, d, input itpm_ptr_t dl);
        return '{op, id, '{32'(c), 32'(s), 32'(d)}, dl};
    endfunction : mk

    // Append one table row
    task automatic add(input itpm_op_e op, input itpm_id_t id, input logic [11:0] c, s, d,
                       input itpm_ptr_t dl, input logic ca, input logic [11:0] ec, es, ed,
                       input logic cn, er);
        rows.push_back('{mk(op, id, c, s, d, dl), ca, '{32'(ec), 32'(es), 32'(ed)}, cn, er});
    endtask : add

    // Compare and count
    task automatic check(input logic [127:0] seen, exp);
        comparisons++;
        if (seen !== exp) begin
            mismatches++;
            $display("Error at %0t: seen %0h expected %0h", $time, seen, exp);
        end
    endtask : check

    // Verdict and end of run
    task automatic results();
        if (mismatches == 0 && comparisons > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask : results

    // Watchdog, far beyond the roughly sixty cycles of the run
    initial begin
        #100000;
        mismatches++;
        results();
    end

    // ****************************************************************
    // Main sequence
    // ****************************************************************
    initial begin
        add(OP_START,   3, 12'h100, 12'h200, 12'h300, 32'h0, 1, 12'h100, 12'h200, 12'h300, 1, 0);
        add(OP_MODIFY,  3, 12'h0, 12'h0, 12'h0, 32'h10, 1, 12'h100, 12'h200, 12'h310, 1, 0);
        add(OP_DISC,    3, 12'h0, 12'h0, 12'h0, 32'h0, 0, 12'h0, 12'h0, 12'h0, 0, 0);
        add(OP_START,   5, 12'hA00, 12'hB00, 12'hC00, 32'h0, 1, 12'hA00, 12'hB00, 12'hC00, 1, 0);
        add(OP_SAVE_DP, 5, 12'h0, 12'h0, 12'h0, 32'h0, 1, 12'hA00, 12'hB00, 12'hC00, 1, 0);
        add(OP_MODIFY,  5, 12'h0, 12'h0, 12'h0, 32'hFFFFFFE0, 1, 12'hA00, 12'hB00, 12'hBE0, 1, 0);
        add(OP_DISC,    5, 12'h0, 12'h0, 12'h0, 32'h0, 0, 12'h0, 12'h0, 12'h0, 0, 0);
        add(OP_RECON,   3, 12'h0, 12'h0, 12'h0, 32'h0, 1, 12'h100, 12'h200, 12'h310, 1, 0);
        add(OP_RESTORE, 3, 12'h0, 12'h0, 12'h0, 32'h0, 1, 12'h100, 12'h200, 12'h300, 1, 0);
        add(OP_NEXT,    3, 12'h111, 12'h222, 12'h333, 32'h0, 1, 12'h111, 12'h222, 12'h333, 1, 0);
        add(OP_DISC,    3, 12'h0, 12'h0, 12'h0, 32'h0, 0, 12'h0, 12'h0, 12'h0, 0, 0);
        add(OP_RECON,   5, 12'h0, 12'h0, 12'h0, 32'h0, 1, 12'hA00, 12'hB00, 12'hBE0, 1, 0);
        add(OP_DISC,    5, 12'h0, 12'h0, 12'h0, 32'h0, 0, 12'h0, 12'h0, 12'h0, 0, 0);
        add(OP_RECON,   3, 12'h0, 12'h0, 12'h0, 32'h0, 1, 12'h111, 12'h222, 12'h333, 1, 0);
        add(OP_DISC,    3, 12'h0, 12'h0, 12'h0, 32'h0, 0, 12'h0, 12'h0, 12'h0, 0, 0);
        add(OP_START,   7, 12'h700, 12'h800, 12'h900, 32'h0, 1, 12'h700, 12'h800, 12'h900, 1, 0);
        add(OP_DISC,    7, 12'h0, 12'h0, 12'h0, 32'h0, 0, 12'h0, 12'h0, 12'h0, 0, 0);
        add(OP_RECON,   7, 12'h0, 12'h0, 12'h0, 32'h0, 1, 12'h700, 12'h800, 12'h900, 1, 0);
        add(OP_NONE,    7, 12'h0, 12'h0, 12'h0, 32'h0, 1, 12'h700, 12'h800, 12'h900, 1, 1);
        add(OP_START,   9, 12'h1, 12'h2, 12'h3, 32'h0, 1, 12'h700, 12'h800, 12'h900, 1, 1);
        add(OP_DISC,    7, 12'h0, 12'h0, 12'h0, 32'h0, 0, 12'h0, 12'h0, 12'h0, 0, 0);
        add(OP_RECON,  15, 12'h0, 12'h0, 12'h0, 32'h0, 0, 12'h0, 12'h0, 12'h0, 0, 1);
        add(OP_MODIFY,  7, 12'h0, 12'h0, 12'h0, 32'h4, 0, 12'h0, 12'h0, 12'h0, 0, 1);
        // Reset values
        repeat (6) @(posedge clock);
        rst <= 1'b0;
        #1;
        check({act_q, cur_id_q, connected_q, busy_q, reject_q}, '0);
        // Table of ordinary cases
        foreach (rows[i]) begin
            itpm_target_inst.go(rows[i].r);
            #1;
            if (rows[i].r.op == OP_RECON && !rows[i].er) begin
                check(busy_q, 1'b1);
                check(cur_id_q, rows[i].r.id);
                @(posedge clock);
                #1;
            end
            check(reject_q, rows[i].er);
            check(connected_q, rows[i].cn);
            check(busy_q, 1'b0);
            if (rows[i].ca) begin
                check(act_q, rows[i].ea);
            end
        end
        // Request while a reconnect load is running is refused
        @(posedge clock);
        itpm_target_inst.put(mk(OP_RECON, 5, 12'h0, 12'h0, 12'h0, 32'h0));
        itpm_target_inst.put(mk(OP_DISC, 5, 12'h0, 12'h0, 12'h0, 32'h0));
        itpm_target_inst.idle();
        #1;
        check(reject_q, 1'b1);
        check({connected_q, act_q}, {1'b1, 32'hA00, 32'hB00, 32'hBE0});
        // Reset in mid-run clears the active state
        @(posedge clock);
        rst <= 1'b1;
        @(posedge clock);
        rst <= 1'b0;
        #1;
        check({act_q, connected_q}, '0);
        results();
    end

endmodule : itpm_ptr_mgr_test

/* File: test/itpm_target.sv */
/*
 * Partner model: a bus target that sends pointer messages, disconnects and
 * reconnects, seen as requests on the pointer manager's request port.
 * Assumes the bench calls its tasks just after a rising edge of clock.
 */
`timescale 1ns/1ns

module itpm_target
    import itpm_pkg::*;
(
    // Clock
    input  wire logic clock,
    // Request port toward the pointer manager
    output logic      req_valid,
    output itpm_req_s req
);

    // ****************************************************************
    // Request driving
    // ****************************************************************
    // Idle request port at time zero
    initial begin
        req_valid = 1'b0;
        req       = '0;
    end

    // Hold one request for exactly one edge; a save message precedes a
    // disconnect only when the bench orders it so and the pointer
    // value is never read back as a transfer length
    task automatic put(input itpm_req_s r);
        req_valid <= 1'b1;
        req       <= r;
        @(posedge clock);
    endtask : put

    // Release: stale fields turn to their inverse so nothing reads them
    task automatic idle();
        req_valid <= 1'b0;
        req       <= ~req;
    endtask : idle

    // One isolated request
    task automatic go(input itpm_req_s r);
        @(posedge clock);
        put(r);
        idle();
    endtask : go

endmodule : itpm_target
